// ---- src/eeprom_pkg.sv ----
`default_nettype none
package eeprom_pkg;
   localparam int ADDR_W = 9;
   localparam int PAGE_W = 4;
   localparam int PAGE_BYTES = 16;
   localparam int PIN_N = 5;
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_HOLD = 3;
   localparam int PIN_WP = 4;
   localparam logic [4:0] PIN_IDLE = 5'h19;
   localparam logic [3:0] OP_UPPER = 4'h0;
   localparam logic [2:0] OP_READ = 3'h3;
   localparam logic [2:0] OP_WRITE = 3'h2;
   localparam logic [2:0] OP_DISABLE = 3'h4;
   localparam logic [2:0] OP_ENABLE = 3'h6;
   localparam logic [2:0] OP_STAT_RD = 3'h5;
   localparam logic [2:0] OP_STAT_WR = 3'h1;
   localparam int OP_A9_POS = 3;
   localparam int ST_BP_POS = 2;
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic [4:0] BYTE_MAX = 5'h1F;
   localparam int WRITE_TIME_MS = 6;
   localparam int CLK_PERIOD_NS = 4;
   localparam int WRITE_CYCLES_DEF = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TIMER_W = 24;
   typedef enum logic [2:0] {
      P_CMD = 3'h0,
      P_ADDR = 3'h1,
      P_WDATA = 3'h3,
      P_RDATA = 3'h2,
      P_SDATA = 3'h6,
      P_SKIP = 3'h7
   } phase_t;
endpackage : eeprom_pkg
`default_nettype wire

// ---- src/pin_sync_if.sv ----
`default_nettype none
interface pin_sync_if;
   logic [eeprom_pkg::PIN_N-1:0] lvl;
   logic [eeprom_pkg::PIN_N-1:0] rise;
   logic [eeprom_pkg::PIN_N-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : pin_sync_if
`default_nettype wire

// ---- src/pin_sync.sv ----
`default_nettype none
module pin_sync #(
   parameter int WIDTH = eeprom_pkg::PIN_N,
   parameter logic [WIDTH-1:0] RESET_VAL = eeprom_pkg::PIN_IDLE
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pins,
   pin_sync_if.src sp
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] rise;
      logic [WIDTH-1:0] fall;
   } sync_t;
   localparam sync_t SYNC_RESET = '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL, '0, '0};
   sync_t st;
   sync_t next_st;

   // a change counts only once stages two and three agree, filtering metastable flicker
   always_comb begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s3[i];
         end
      end
      next_st.rise = next_st.lvl & ~st.lvl;
      next_st.fall = ~next_st.lvl & st.lvl;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= SYNC_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign sp.lvl = st.lvl;
   assign sp.rise = st.rise;
   assign sp.fall = st.fall;
endmodule : pin_sync
`default_nettype wire

// ---- src/spi_eeprom_port.sv ----
// How it works
// - chip select low selects; high means standby with output released
// - a started programming cycle finishes whatever chip select does
// - nothing is decoded until a chip select falling edge is seen
// - input sampled on clock rise, output changed after clock fall
// - every byte moves most significant bit first
// - write-protect low refuses array and status writes, clears latch
// - write-protect low never aborts a running write cycle
// - host keeps pause high unless pausing, with chip select low
// - pause starts with clock low, else at next clock fall
// - resume happens with clock low, else at next clock fall
// - paused: clock and input ignored, sequence resumes where it stopped
// - output released on pause fall, driven again on pause rise
// - opcode upper nibble zero, bit 3 ninth address, 011 read, 010 write
// - latch set and clear opcodes decoded with bit 3 ignored
// - status read and status write opcodes decoded with bit 3 ignored
// - read or write opcode is followed by one address byte
// - read streams bytes, address increments, wraps to zero
// - latch set only on chip select rise after eight opcode bits
// - page write keeps sixteen bytes, address wraps inside the page
// - write starts only when chip select rises after a whole byte
// - busy: status reads allowed, array reads refused, latch cleared after
// - status: busy bit 0, latch bit 1, protect bits 2 and 3
// - protect codes 0..3 guard none, top quarter, top half, all
// - write cycle starts at chip select rise, lasts at most 6 ms
// - latch cleared at reset and after clear, status write, array write
`default_nettype none
module spi_eeprom_port #(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   input wire logic holdN,
   input wire logic wpN,
   output logic soOut,
   output logic soOe,
   output logic writeBusy
);
   import eeprom_pkg::*;

   typedef struct packed {
      logic armed;
      logic paused;
      phase_t phase;
      logic [2:0] bitCnt;
      logic [4:0] byteNum;
      logic [7:0] shift;
      logic [7:0] cmd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] outShift;
      logic driving;
      logic [PAGE_BYTES-1:0] mask;
      logic [ADDR_W-PAGE_W-1:0] wrPage;
      logic [PAGE_BYTES-1:0][7:0] pageBuf;
      logic [1:0] capBp;
      logic [1:0] pendBp;
      logic pendStatus;
      logic write_enable_latch;
      logic [1:0] bp;
      logic busy;
      logic [TIMER_W-1:0] timer;
      logic soOut;
      logic soOe;
   } state_t;

   localparam state_t ST_RESET = '{phase: P_CMD, bp: BP_RESET, default: '0};
   localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(WRITE_CYCLES);
   localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(1);

   state_t st;
   state_t next_st;
   logic [7:0] mem [0:(1 << ADDR_W) - 1];
   logic csLvl;
   logic sckLvl;
   logic siLvl;
   logic holdLvl;
   logic wpLvl;
   logic edgeOk;
   logic commitNow;
   logic [7:0] inByte;
   logic [ADDR_W-1:0] newAddr;
   logic [ADDR_W-1:0] incAddr;

   pin_sync_if syn();

   pin_sync #(.WIDTH(PIN_N), .RESET_VAL(PIN_IDLE)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pins({wpN, holdN, si, sck, csN}),
      .sp(syn)
   );

   function automatic logic isOp(input logic [7:0] b, input logic [2:0] code);
      isOp = (b[7:4] == OP_UPPER) && (b[2:0] == code);
   endfunction : isOp

   function automatic logic [7:0] statusByte(input state_t s);
      statusByte = {4'h0, s.bp, s.write_enable_latch, s.busy};
   endfunction : statusByte

   function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [1:0] code);
      case (code)
         2'h0: isProtected = 1'b0;
         2'h1: isProtected = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
         2'h2: isProtected = a[ADDR_W-1];
         default: isProtected = 1'b1;
      endcase
   endfunction : isProtected

   assign csLvl = syn.lvl[PIN_CS];
   assign sckLvl = syn.lvl[PIN_SCK];
   assign siLvl = syn.lvl[PIN_SI];
   assign holdLvl = syn.lvl[PIN_HOLD];
   assign wpLvl = syn.lvl[PIN_WP];
   assign edgeOk = st.armed && !csLvl && !st.paused;
   assign inByte = {st.shift[6:0], siLvl};
   assign newAddr = {st.addr[ADDR_W-1], inByte};
   assign incAddr = st.addr + ADDR_W'(1);
   assign commitNow = st.busy && (st.timer == TIMER_LAST) && !st.pendStatus;

   always_comb begin
      next_st = st;
      if (syn.fall[PIN_CS]) begin
         next_st.armed = 1'b1;
         next_st.phase = P_CMD;
         next_st.bitCnt = 3'h0;
         next_st.byteNum = 5'h0;
         // a frame during a running cycle must not empty the page being programmed
         if (!st.busy) begin
            next_st.mask = '0;
         end
         next_st.driving = 1'b0;
      end
      // pause follows the pin only while the clock is low; the edge that lowers
      // the clock is still judged by the old pause state
      if (!sckLvl) begin
         next_st.paused = !holdLvl;
      end
      if (edgeOk && syn.rise[PIN_SCK]) begin
         next_st.shift = inByte;
         next_st.bitCnt = st.bitCnt + 3'h1;
         if (st.bitCnt == 3'h7) begin
            if (st.byteNum != BYTE_MAX) begin
               next_st.byteNum = st.byteNum + 5'h1;
            end
            case (st.phase)
               P_CMD: begin
                  next_st.cmd = inByte;
                  next_st.addr[ADDR_W-1] = inByte[OP_A9_POS];
                  next_st.phase = P_SKIP;
                  if (isOp(inByte, OP_READ) || isOp(inByte, OP_WRITE)) begin
                     next_st.phase = P_ADDR;
                  end else if (isOp(inByte, OP_STAT_WR)) begin
                     next_st.phase = P_WDATA;
                  end else if (isOp(inByte, OP_STAT_RD)) begin
                     next_st.phase = P_SDATA;
                     next_st.outShift = statusByte(st);
                  end
               end
               P_ADDR: begin
                  next_st.addr = newAddr;
                  if (st.busy) begin
                     next_st.phase = P_SKIP;
                  end else if (isOp(st.cmd, OP_READ)) begin
                     next_st.phase = P_RDATA;
                     next_st.outShift = mem[newAddr];
                  end else begin
                     next_st.phase = P_WDATA;
                  end
               end
               P_WDATA: begin
                  if (isOp(st.cmd, OP_STAT_WR)) begin
                     next_st.capBp = inByte[ST_BP_POS+1:ST_BP_POS];
                  end else begin
                     next_st.pageBuf[st.addr[PAGE_W-1:0]] = inByte;
                     next_st.mask[st.addr[PAGE_W-1:0]] = 1'b1;
                     next_st.addr[PAGE_W-1:0] = st.addr[PAGE_W-1:0] + PAGE_W'(1);
                  end
               end
               P_RDATA: begin
                  next_st.addr = incAddr;
                  next_st.outShift = mem[incAddr];
               end
               P_SDATA: begin
                  next_st.outShift = statusByte(st);
               end
               default: begin
               end
            endcase
         end
      end
      if (edgeOk && syn.fall[PIN_SCK] && (st.phase == P_RDATA || st.phase == P_SDATA)) begin
         next_st.soOut = st.outShift[7];
         next_st.outShift = {st.outShift[6:0], 1'b0};
         next_st.driving = 1'b1;
      end
      if (syn.rise[PIN_CS]) begin
         next_st.phase = P_SKIP;
         next_st.driving = 1'b0;
         if (st.armed && st.bitCnt == 3'h0 && !st.busy) begin
            if (isOp(st.cmd, OP_ENABLE) && st.byteNum == 5'h1 && wpLvl) begin
               next_st.write_enable_latch = 1'b1;
            end else if (isOp(st.cmd, OP_DISABLE) && st.byteNum == 5'h1) begin
               next_st.write_enable_latch = 1'b0;
            end else if (isOp(st.cmd, OP_STAT_WR) && st.byteNum == 5'h2 && st.write_enable_latch && wpLvl) begin
               next_st.busy = 1'b1;
               next_st.timer = TIMER_LOAD;
               next_st.pendStatus = 1'b1;
               next_st.pendBp = st.capBp;
            end else if (isOp(st.cmd, OP_WRITE) && st.byteNum >= 5'h3 && st.write_enable_latch && wpLvl) begin
               next_st.busy = 1'b1;
               next_st.timer = TIMER_LOAD;
               next_st.pendStatus = 1'b0;
               // page kept aside: later frames during the cycle move the address
               next_st.wrPage = st.addr[ADDR_W-1:PAGE_W];
            end
         end
      end
      // the countdown ignores chip select and write-protect once started
      if (st.busy) begin
         if (st.timer == TIMER_LAST) begin
            next_st.busy = 1'b0;
            next_st.write_enable_latch = 1'b0;
            if (st.pendStatus) begin
               next_st.bp = st.pendBp;
            end
         end else begin
            next_st.timer = st.timer - TIMER_LAST;
         end
      end
      if (!wpLvl) begin
         next_st.write_enable_latch = 1'b0;
      end
      next_st.soOe = st.armed && !csLvl && holdLvl && next_st.driving;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // array contents are not reset: they model nonvolatile cells
   always_ff @(posedge ref_clk) begin
      if (commitNow) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (st.mask[i] && !isProtected({st.wrPage, PAGE_W'(i)}, st.bp)) begin
               mem[{st.wrPage, PAGE_W'(i)}] <= st.pageBuf[i];
            end
         end
      end
   end

   assign soOut = st.soOut;
   assign soOe = st.soOe;
   assign writeBusy = st.busy;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   standby_release_a: assert property (csLvl |=> !st.soOe)
      else $error("output driven while deselected");
   cycle_runs_a: assert property (st.busy && st.timer != TIMER_LAST |=> st.busy)
      else $error("write cycle ended early");
   unarmed_idle_a: assert property (!st.armed |-> !st.soOe && !st.busy && !st.write_enable_latch)
      else $error("activity before first select");
   protect_clears_a: assert property (!wpLvl |=> !st.write_enable_latch)
      else $error("latch survived write-protect");
   protect_no_abort_a: assert property (st.busy && !wpLvl && st.timer != TIMER_LAST
      |=> st.busy && st.timer == $past(st.timer) - TIMER_LAST)
      else $error("write-protect disturbed a running cycle");
   pause_freeze_a: assert property (st.paused |=> st.bitCnt == $past(st.bitCnt)
      && st.shift == $past(st.shift))
      else $error("sequence moved while paused");
   pause_release_a: assert property (!holdLvl |=> !st.soOe)
      else $error("output driven while pause low");
   done_clears_a: assert property (st.busy && st.timer == TIMER_LAST
      |=> !st.busy && !st.write_enable_latch)
      else $error("latch not cleared after write");
   busy_no_read_a: assert property (st.busy && st.phase == P_ADDR && edgeOk
      && syn.rise[PIN_SCK] && st.bitCnt == 3'h7 |=> st.phase == P_SKIP)
      else $error("array read during write cycle");
   latch_set_a: assert property ($rose(st.write_enable_latch) |-> $past(syn.rise[PIN_CS]))
      else $error("latch set without select rise");
   cycle_start_a: assert property ($rose(st.busy) |-> st.timer == TIMER_LOAD
      && $past(syn.rise[PIN_CS]))
      else $error("write cycle started wrongly");
   out_on_fall_a: assert property (!$stable(st.soOut) |-> $past(syn.fall[PIN_SCK]))
      else $error("output changed away from clock fall");
   count_on_rise_a: assert property (st.bitCnt != $past(st.bitCnt)
      |-> $past(syn.rise[PIN_SCK]) || $past(syn.fall[PIN_CS]))
      else $error("bit counter moved without clock rise");
   arm_on_select_a: assert property ($rose(st.armed) |-> $past(syn.fall[PIN_CS]))
      else $error("armed without select fall");
   frame_restart_a: assert property (syn.fall[PIN_CS]
      |=> st.phase == P_CMD && st.bitCnt == 3'h0)
      else $error("frame did not restart on select");
   deselect_skip_a: assert property (syn.rise[PIN_CS]
      |=> st.phase == P_SKIP && !st.driving)
      else $error("frame continued after deselect");
   latch_needs_wp_a: assert property ($rose(st.write_enable_latch) |-> $past(wpLvl))
      else $error("latch set while write-protect low");
   start_needs_latch_a: assert property ($rose(st.busy)
      |-> $past(wpLvl) && $past(st.write_enable_latch))
      else $error("write cycle started without latch");
   latch_fall_cause_a: assert property ($fell(st.write_enable_latch)
      |-> $past(syn.rise[PIN_CS]) || $fell(st.busy) || !$past(wpLvl))
      else $error("latch cleared without cause");
   protect_update_a: assert property (!$stable(st.bp) |-> $fell(st.busy))
      else $error("protect bits changed outside a cycle end");
   timer_range_a: assert property (st.busy
      |-> st.timer != '0 && st.timer <= TIMER_LOAD)
      else $error("write timer out of range");
   page_stays_a: assert property (st.phase == P_WDATA
      |=> $stable(st.addr[ADDR_W-1:PAGE_W]))
      else $error("page write left its page");
   addr_load_a: assert property (st.phase == P_ADDR && edgeOk
      && syn.rise[PIN_SCK] && st.bitCnt == 3'h7 |=> st.addr[ADDR_W-2:0] == $past(inByte))
      else $error("address byte not taken");
   read_step_a: assert property (st.phase == P_RDATA && edgeOk
      && syn.rise[PIN_SCK] && st.bitCnt == 3'h7 |=> st.addr == $past(st.addr) + ADDR_W'(1))
      else $error("read address did not advance");
   status_cmd_a: assert property (st.phase == P_CMD && edgeOk && syn.rise[PIN_SCK]
      && st.bitCnt == 3'h7 && isOp(inByte, OP_STAT_RD) |=> st.phase == P_SDATA)
      else $error("status read not decoded");
   bad_opcode_a: assert property (st.phase == P_CMD && edgeOk && syn.rise[PIN_SCK]
      && st.bitCnt == 3'h7 && inByte[7:4] != OP_UPPER |=> st.phase == P_SKIP)
      else $error("unknown opcode accepted");
endmodule : spi_eeprom_port
`default_nettype wire

// ---- sim/spi_host_model.sv ----
`default_nettype none
module spi_host_model (
   input wire logic ref_clk,
   input wire logic soOut,
   input wire logic soOe,
   output logic csN,
   output logic sck,
   output logic si,
   output logic holdN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic soLast = 1'b0;
   logic oeSeen = 1'b0;
   // the line has no pull: when released it shows the inverse of the last bit
   wire logic soWire = soOe ? soOut : ~soLast;
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      holdN = 1'b1;
   end
   always @(posedge ref_clk) begin
      if (soOe) begin
         soLast <= soOut;
         oeSeen <= 1'b1;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic start_frame();
      csN <= 1'b0;
      oeSeen <= 1'b0;
      tick(8);
   endtask : start_frame
   task automatic end_frame();
      sck <= 1'b0;
      tick(8);
      csN <= 1'b1;
      tick(8);
   endtask : end_frame
   // mode 0: data set while clock low, both ends sample at the rise
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sck <= 1'b0;
         si <= tx[i];
         tick(8);
         rx = {rx[6:0], soWire};
         sck <= 1'b1;
         tick(8);
      end
   endtask : xfer
   task automatic pause();
      sck <= 1'b0;
      tick(8);
      holdN <= 1'b0;
      tick(8);
   endtask : pause
   task automatic resume();
      sck <= 1'b0;
      tick(8);
      holdN <= 1'b1;
      tick(8);
   endtask : resume
endmodule : spi_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import eeprom_pkg::*;
   localparam int WCYC = 1000;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wpN = 1'b1;
   wire logic csN, sck, si, holdN, soOut, soOe, writeBusy;
   int fails = 0;
   int num_checks = 0;
   logic [7:0] mem [512];
   logic [1:0] bp = 2'h0;
   logic [7:0] rx;
   initial forever #2 ref_clk = ~ref_clk;
   spi_eeprom_port #(.WRITE_CYCLES(WCYC)) u_spi_eeprom_port (.ref_clk(ref_clk),
      .rst_n(rst_n), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN),
      .soOut(soOut), .soOe(soOe), .writeBusy(writeBusy));
   spi_host_model u_spi_host_model (.ref_clk(ref_clk), .soOut(soOut), .soOe(soOe),
      .csN(csN), .sck(sck), .si(si), .holdN(holdN));
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // upper quarter and upper half counted from the top of the array
   function automatic int lim(input logic [1:0] b);
      return b == 2'h0 ? 512 : b == 2'h1 ? 384 : b == 2'h2 ? 256 : 0;
   endfunction : lim
   task automatic op(input logic [7:0] c, input int n, input logic [7:0] d);
      u_spi_host_model.start_frame();
      u_spi_host_model.xfer(c, 8, rx);
      if (n > 0) u_spi_host_model.xfer(d, n, rx);
      u_spi_host_model.end_frame();
   endtask : op
   task automatic status_read_cmd(input logic [7:0] exp);
      op({OP_UPPER, 1'b1, OP_STAT_RD}, 8, 8'h00);
      chk(rx, exp);
   endtask : status_read_cmd
   task automatic wait_idle();
      for (int i = 0; i < WCYC && writeBusy !== 1'b0; i++) @(posedge ref_clk);
      chk(writeBusy, 1'b0);
   endtask : wait_idle
   task automatic wr(input logic [8:0] a, input int n, input logic [7:0] base,
                     input logic wpl);
      logic [8:0] p;
      p = a;
      op({OP_UPPER, 1'b0, OP_ENABLE}, 0, 8'h00);
      u_spi_host_model.start_frame();
      u_spi_host_model.xfer({OP_UPPER, a[8], OP_WRITE}, 8, rx);
      u_spi_host_model.xfer(a[7:0], 8, rx);
      for (int i = 0; i < n; i++) begin
         u_spi_host_model.xfer(8'(base + i), 8, rx);
         if (int'(p) < lim(bp)) mem[p] = 8'(base + i);
         p = {p[8:4], p[3:0] + 4'h1};
      end
      u_spi_host_model.end_frame();
      if (wpl) wpN <= 1'b0;
      chk(writeBusy, 1'b1);
      status_read_cmd({4'h0, bp, ~wpl, 1'b1});
      u_spi_host_model.start_frame();
      u_spi_host_model.xfer({OP_UPPER, 1'b0, OP_READ}, 8, rx);
      u_spi_host_model.xfer(8'h00, 8, rx);
      u_spi_host_model.xfer(8'h00, 8, rx);
      u_spi_host_model.end_frame();
      chk(u_spi_host_model.oeSeen, 1'b0);
      wait_idle();
      wpN <= 1'b1;
      status_read_cmd({4'h0, bp, 2'h0});
   endtask : wr
   task automatic rd(input logic [8:0] a, input int n);
      logic [8:0] p;
      p = a;
      u_spi_host_model.start_frame();
      u_spi_host_model.xfer({OP_UPPER, a[8], OP_READ}, 8, rx);
      u_spi_host_model.xfer(a[7:0], 8, rx);
      for (int i = 0; i < n; i++) begin
         if (i == 1) begin
            u_spi_host_model.pause();
            chk(soOe, 1'b0);
            u_spi_host_model.xfer(8'hFF, 3, rx);
            u_spi_host_model.resume();
            chk(soOe, 1'b1);
         end
         u_spi_host_model.xfer(8'h00, 8, rx);
         chk(rx, mem[p]);
         p = p + 9'h001;
      end
      u_spi_host_model.end_frame();
      chk(soOe, 1'b0);
   endtask : rd
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      u_spi_host_model.tick(8);
      status_read_cmd(8'h00);
      op(8'h0E, 0, 8'h00);
      status_read_cmd(8'h02);
      op(8'h0C, 0, 8'h00);
      status_read_cmd(8'h00);
      wr(9'h1F8, 18, 8'h40, 1'b0);
      wr(9'h000, 2, 8'h90, 1'b1);
      rd(9'h1F8, 10);
      wpN <= 1'b0;
      op({OP_UPPER, 1'b0, OP_ENABLE}, 0, 8'h00);
      status_read_cmd(8'h00);
      wpN <= 1'b1;
      op({OP_UPPER, 1'b0, OP_ENABLE}, 0, 8'h00);
      op({OP_UPPER, 1'b1, OP_STAT_WR}, 8, 8'h04);
      wait_idle();
      bp = 2'h1;
      status_read_cmd(8'h04);
      wr(9'h1FC, 1, 8'hEE, 1'b0);
      rd(9'h1FB, 2);
      op({OP_UPPER, 1'b0, OP_ENABLE}, 0, 8'h00);
      u_spi_host_model.start_frame();
      u_spi_host_model.xfer({OP_UPPER, 1'b0, OP_WRITE}, 8, rx);
      u_spi_host_model.xfer(8'h00, 8, rx);
      u_spi_host_model.xfer(8'h11, 8, rx);
      u_spi_host_model.xfer(8'h22, 3, rx);
      u_spi_host_model.end_frame();
      chk(writeBusy, 1'b0);
      status_read_cmd(8'h06);
      close_out();
   end
   // the whole sequence needs about 14000 cycles
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      close_out();
   end
endmodule : testbench
`default_nettype wire
